// File: verilog/crc_pkg.sv
package crc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CRC_BUS_W      = 32;  // AHB data and address width.
  localparam int CRC_DATA_W     = 16;  // Widest data element and remainder.
  localparam int CRC_CNT_W      = 5;   // Valid word count width.
  localparam int CRC_LEN_W      = 4;   // Length field width.
  localparam int CRC_DEPTH_MAX  = 16;  // Physical FIFO depth.

  // ----------------------------------------------------------------
  // Depth selection and counts
  // ----------------------------------------------------------------
  localparam logic [CRC_LEN_W-1:0] CRC_LEN_BYTE_MAX = 4'h7;    // Above this, depth is 8.
  localparam logic [CRC_CNT_W-1:0] CRC_DEPTH_LONG   = 5'h08;   // Depth for long elements.
  localparam logic [CRC_CNT_W-1:0] CRC_DEPTH_SHORT  = 5'h10;   // Depth for short elements.
  localparam logic [CRC_CNT_W-1:0] CRC_CNT_ONE      = 5'h01;   // Count before draining.

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_OFS_CTRL = 8'h00;  // Go, stop in idle, length.
  localparam logic [7:0] CRC_OFS_STAT = 8'h04;  // Count, full, empty, busy.
  localparam logic [7:0] CRC_OFS_DATA = 8'h08;  // Write pushes, read gives remainder.
  localparam logic [7:0] CRC_OFS_POLY = 8'h0C;  // Feedback polynomial.
  localparam logic [7:0] CRC_OFS_RSLT = 8'h10;  // Remainder, writable as a seed.
  localparam logic [7:0] CRC_OFS_IRQS = 8'h14;  // Sticky interrupt status.
  localparam logic [7:0] CRC_OFS_IRQM = 8'h18;  // Interrupt mask.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CRC_CTRL_GO_POS   = 0;   // Shift go bit.
  localparam int CRC_CTRL_SIDL_POS = 1;   // Stop in idle bit.
  localparam int CRC_CTRL_LEN_LSB  = 8;   // Length field, four bits.
  localparam int CRC_STAT_FULL_POS = 8;   // FIFO full flag.
  localparam int CRC_STAT_EMPT_POS = 9;   // FIFO empty flag.
  localparam int CRC_STAT_BUSY_POS = 10;  // Shifter in mid word.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CRC_LEN_W-1:0]  CRC_LEN_RST  = 4'hF;
  localparam logic [CRC_DATA_W-1:0] CRC_POLY_RST = 16'h1021;
  localparam logic [CRC_DATA_W-1:0] CRC_RSLT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // AHB codes and shifter states
  // ----------------------------------------------------------------
  localparam logic [1:0] CRC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] CRC_HSIZE_BYTE    = 3'h0;
  localparam logic [2:0] CRC_HSIZE_HALF    = 3'h1;

  typedef enum logic [0:0] {
    CRC_IDLE  = 1'b0,
    CRC_SHIFT = 1'b1
  } crc_state_type;

endpackage

// File: verilog/crc_fifo_if.sv
`timescale 1ns/10ps
// Carries the push, pop and status of the word FIFO.
interface crc_fifo_if;
  import crc_pkg::*;
  logic                  push;       // Store one word.
  logic [CRC_DATA_W-1:0] push_data;  // Word to store.
  logic                  pop;        // Drop the head word.
  logic                  clear;      // Roll the count over to zero.
  logic [CRC_DATA_W-1:0] head;       // Oldest stored word.
  logic [CRC_CNT_W-1:0]  count;      // Number of valid words.
  modport fifo (input push, push_data, pop, clear, output head, count);
  modport user (output push, push_data, pop, clear, input head, count);
endinterface

// File: verilog/crc_fifo.sv
`timescale 1ns/10ps
module crc_fifo #(
  parameter int DEPTH = crc_pkg::CRC_DEPTH_MAX
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  crc_fifo_if.fifo  port
);
  import crc_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [CRC_DATA_W-1:0] mem [DEPTH];  // Word storage.
  logic [PW-1:0]         wr_ptr;       // Next slot to write.
  logic [PW-1:0]         rd_ptr;       // Head slot.
  logic [CRC_CNT_W-1:0]  count;        // Valid words.

  assign port.head  = mem[rd_ptr];
  assign port.count = count;

  // Storage takes the word on push; contents need no reset.
  always_ff @(posedge clk_i) begin
    if (port.push && !port.clear) begin
      mem[wr_ptr] <= port.push_data;
    end
  end

  // Pointers and count; a clear returns everything to empty.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (port.clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (port.push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (port.pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (port.push && !port.pop) begin
        count <= count + 1'b1;
      end else if (port.pop && !port.push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// File: verilog/crc_lfsr.sv
`timescale 1ns/10ps
module crc_lfsr #(
  parameter int W = crc_pkg::CRC_DATA_W
) (
  input  wire logic                            clk_i,
  input  wire logic                            reset_n_i,
  input  wire logic                            shift_i,
  input  wire logic                            bit_i,
  input  wire logic [crc_pkg::CRC_LEN_W-1:0]   len_i,
  input  wire logic [W-1:0]                    poly_i,
  input  wire logic                            load_i,
  input  wire logic [W-1:0]                    load_val_i,
  output logic      [W-1:0]                    rem_o
);
  import crc_pkg::*;

  logic [W-1:0] rem;       // Remainder.
  logic [W-1:0] mask;      // Bits in use for this length.
  logic         feedback;  // Incoming bit against remainder top.
  logic [W-1:0] next_rem;  // Remainder after one shift.

  assign rem_o = rem;

  // Remainder width is the length field plus one.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      mask[i] = (i <= int'(len_i));
    end
    feedback = bit_i ^ rem[len_i];
    next_rem = ((rem << 1) ^ (feedback ? poly_i : '0)) & mask;
  end

  // One bit per shift strobe; a load seeds the remainder.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rem <= CRC_RSLT_RST;
    end else if (load_i) begin
      rem <= load_val_i & mask;
    end else if (shift_i) begin
      rem <= next_rem;
    end
  end

endmodule

// File: verilog/crc_top.sv
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
// ------------------------------------------------------------------
// What this block does
// - FIFO depth 8 if length above 7, else 16.
// - Element is length plus one bits; upper bits ignored.
// - Writing the top byte adds one word.
// - Shift while go and count nonzero; pop decrements.
// - One bit per clock, no gaps.
// - Full at depth, empty at zero.
// - Write while full rolls count to zero, no interrupt.
// - Interrupt when count goes one to zero.
// - Sleep freezes state; resumes afterwards.
// - Idle with stop bit freezes; interrupts still pass.
// ------------------------------------------------------------------
module crc_top (
  input  wire logic                           clk_i,
  input  wire logic                           reset_n_i,
  input  wire logic                           hsel_i,
  input  wire logic [crc_pkg::CRC_BUS_W-1:0]  haddr_i,
  input  wire logic [1:0]                     htrans_i,
  input  wire logic                           hwrite_i,
  input  wire logic [2:0]                     hsize_i,
  input  wire logic [crc_pkg::CRC_BUS_W-1:0]  hwdata_i,
  input  wire logic                           hready_i,
  output logic      [crc_pkg::CRC_BUS_W-1:0]  hrdata_o,
  output logic                                hreadyout_o,
  output logic                                hresp_o,
  input  wire logic                           sleep_i,
  input  wire logic                           idle_i,
  output logic                                irq_o
);
  import crc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  crc_fifo_if fifo_bus ();                 // Link to the word FIFO.

  logic                   rd_pend;         // Read data phase in progress.
  logic                   wr_pend;         // Write data phase in progress.
  logic [7:0]             dp_addr;         // Latched word offset.
  logic [3:0]             dp_be;           // Latched byte enables.
  logic [3:0]             ap_be;           // Byte enables of address phase.
  logic                   ap_take;         // Address phase accepted.

  logic                   shift_go;        // Shift go bit.
  logic                   stop_in_idle;    // Stop in idle bit.
  logic [CRC_LEN_W-1:0]   poly_length;     // Length field.
  logic [CRC_DATA_W-1:0]  poly;            // Feedback polynomial.
  logic [7:0]             stage_lo;        // Low byte held for long words.
  logic                   irq_stat;        // Sticky drain event.
  logic                   irq_mask;        // Drain event enable.

  logic                   run_en;          // Clocks available to the block.
  logic                   long_elem;       // Element wider than a byte.
  logic [CRC_CNT_W-1:0]   depth;           // Active FIFO depth.
  logic                   fifo_full;       // Full flag.
  logic                   fifo_empty;      // Empty flag.
  logic [CRC_DATA_W-1:0]  elem_mask;       // Bits of one element.

  logic                   data_wr;         // Data register write commits.
  logic                   msb_lane_wr;     // Write covers the top byte.
  logic [CRC_DATA_W-1:0]  word_in;         // Assembled element.
  logic                   do_push;         // Store the element.
  logic                   do_wrap;         // Write while full.

  crc_state_type          state;           // Shifter state.
  logic [CRC_LEN_W-1:0]   bit_idx;         // Next bit in mid word.
  logic [CRC_LEN_W-1:0]   cur_idx;         // Bit shifted this cycle.
  logic                   shift_now;       // Shift a bit this cycle.
  logic                   do_pop;          // Last bit of word shifted.
  logic                   drain_evt;       // Count went one to zero.

  logic                   rslt_wr;         // Seed write to remainder.
  logic [CRC_DATA_W-1:0]  remainder;       // Current CRC remainder.
  logic [CRC_BUS_W-1:0]   rd_mux;          // Selected read value.

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------

  // A transfer is taken when the slave is ready and a NONSEQ is seen.
  assign ap_take = hsel_i && hready_i && hreadyout_o
                   && (htrans_i == CRC_HTRANS_NONSEQ);

  // Byte lanes from size and low address bits.
  always_comb begin
    unique case (hsize_i)
      CRC_HSIZE_BYTE: ap_be = 4'h1 << haddr_i[1:0];
      CRC_HSIZE_HALF: ap_be = 4'h3 << {haddr_i[1], 1'b0};
      default:        ap_be = 4'hF;
    endcase
  end

  // Latch the address phase; reads add one wait state.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_pend     <= 1'b0;
      wr_pend     <= 1'b0;
      dp_addr     <= 8'h00;
      dp_be       <= 4'h0;
      hreadyout_o <= 1'b1;
    end else begin
      // A pending read finishes in the next cycle.
      if (rd_pend) begin
        rd_pend     <= 1'b0;
        hreadyout_o <= 1'b1;
      end else if (ap_take) begin
        rd_pend     <= !hwrite_i;
        hreadyout_o <= hwrite_i;
      end
      wr_pend <= ap_take && hwrite_i;
      if (ap_take) begin
        dp_addr <= {haddr_i[7:2], 2'b00};
        dp_be   <= ap_be;
      end
    end
  end

  // The response is always OKAY.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // Control and polynomial writes; unmapped writes are dropped.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_go     <= 1'b0;
      stop_in_idle <= 1'b0;
      poly_length  <= CRC_LEN_RST;
      poly         <= CRC_POLY_RST;
    end else if (wr_pend) begin
      if (dp_addr == CRC_OFS_CTRL) begin
        if (dp_be[0]) begin
          shift_go     <= hwdata_i[CRC_CTRL_GO_POS];
          stop_in_idle <= hwdata_i[CRC_CTRL_SIDL_POS];
        end
        if (dp_be[1]) begin
          poly_length <= hwdata_i[CRC_CTRL_LEN_LSB +: CRC_LEN_W];
        end
      end
      if (dp_addr == CRC_OFS_POLY) begin
        if (dp_be[0]) begin
          poly[7:0] <= hwdata_i[7:0];
        end
        if (dp_be[1]) begin
          poly[15:8] <= hwdata_i[15:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Power states and FIFO flags
  // ----------------------------------------------------------------

  // Sleep always stops the block; idle stops it only when asked.
  assign run_en = !(sleep_i || (idle_i && stop_in_idle));

  // Elements wider than a byte halve the usable depth.
  assign long_elem  = poly_length > CRC_LEN_BYTE_MAX;
  assign depth      = long_elem ? CRC_DEPTH_LONG : CRC_DEPTH_SHORT;
  assign fifo_full  = fifo_bus.count == depth;
  assign fifo_empty = fifo_bus.count == '0;

  // Only the low length plus one bits of an element are kept.
  always_comb begin
    for (int i = 0; i < CRC_DATA_W; i++) begin
      elem_mask[i] = (i <= int'(poly_length));
    end
  end

  // ----------------------------------------------------------------
  // Data writes into the FIFO
  // ----------------------------------------------------------------

  assign data_wr     = wr_pend && (dp_addr == CRC_OFS_DATA);
  assign msb_lane_wr = long_elem ? dp_be[1] : dp_be[0];

  // Long elements take the low byte from this write or an earlier one.
  always_comb begin
    if (long_elem) begin
      word_in = {hwdata_i[15:8], dp_be[0] ? hwdata_i[7:0] : stage_lo};
    end else begin
      word_in = {8'h00, hwdata_i[7:0]};
    end
    word_in = word_in & elem_mask;
  end

  // The word counts once its top byte is written.
  assign do_push = data_wr && msb_lane_wr && !fifo_full;
  assign do_wrap = data_wr && msb_lane_wr && fifo_full;

  // Keep a lone low byte until the top byte arrives.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage_lo <= 8'h00;
    end else if (data_wr && dp_be[0]) begin
      stage_lo <= hwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------

  // A new word starts at the length bit; mid word uses the counter.
  assign cur_idx   = (state == CRC_IDLE) ? poly_length : bit_idx;
  assign shift_now = shift_go && !fifo_empty && run_en && !do_wrap;
  assign do_pop    = shift_now && (cur_idx == '0);

  // Shifter state advances one bit each clock with no gap.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state   <= CRC_IDLE;
      bit_idx <= '0;
    end else if (do_wrap) begin
      state <= CRC_IDLE;
    end else if (shift_now) begin
      unique case (state)
        CRC_IDLE, CRC_SHIFT: begin
          if (cur_idx == '0) begin
            state <= CRC_IDLE;
          end else begin
            state   <= CRC_SHIFT;
            bit_idx <= cur_idx - 1'b1;
          end
        end
      endcase
    end
  end

  // FIFO handshake.
  assign fifo_bus.push      = do_push;
  assign fifo_bus.push_data = word_in;
  assign fifo_bus.pop       = do_pop;
  assign fifo_bus.clear     = do_wrap;

  crc_fifo #(
    .DEPTH (CRC_DEPTH_MAX)
  ) u_fifo (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .port      (fifo_bus)
  );

  // The remainder may be seeded through its own register.
  assign rslt_wr = wr_pend && (dp_addr == CRC_OFS_RSLT) && (&dp_be[1:0]);

  crc_lfsr #(
    .W (CRC_DATA_W)
  ) u_lfsr (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .shift_i    (shift_now),
    .bit_i      (fifo_bus.head[cur_idx]),
    .len_i      (poly_length),
    .poly_i     (poly),
    .load_i     (rslt_wr),
    .load_val_i (hwdata_i[CRC_DATA_W-1:0]),
    .rem_o      (remainder)
  );

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------

  // Draining the last word; a rollover never passes through one.
  assign drain_evt = do_pop && !do_push && (fifo_bus.count == CRC_CNT_ONE);

  // Sticky status, cleared by writing one; a new event wins.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat <= 1'b0;
    end else if (drain_evt) begin
      irq_stat <= 1'b1;
    end else if (wr_pend && dp_addr == CRC_OFS_IRQS && dp_be[0] && hwdata_i[0]) begin
      irq_stat <= 1'b0;
    end
  end

  // Mask register of the same layout.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_mask <= 1'b0;
    end else if (wr_pend && dp_addr == CRC_OFS_IRQM && dp_be[0]) begin
      irq_mask <= hwdata_i[0];
    end
  end

  // The request keeps flowing even while the block is frozen.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_stat && irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Register selection; unmapped offsets read zero.
  always_comb begin
    rd_mux = '0;
    unique case (dp_addr)
      CRC_OFS_CTRL: begin
        rd_mux[CRC_CTRL_GO_POS]                  = shift_go;
        rd_mux[CRC_CTRL_SIDL_POS]                = stop_in_idle;
        rd_mux[CRC_CTRL_LEN_LSB +: CRC_LEN_W]    = poly_length;
      end
      CRC_OFS_STAT: begin
        rd_mux[CRC_CNT_W-1:0]     = fifo_bus.count;
        rd_mux[CRC_STAT_FULL_POS] = fifo_full;
        rd_mux[CRC_STAT_EMPT_POS] = fifo_empty;
        rd_mux[CRC_STAT_BUSY_POS] = state == CRC_SHIFT;
      end
      CRC_OFS_DATA, CRC_OFS_RSLT: begin
        rd_mux[CRC_DATA_W-1:0] = remainder;
      end
      CRC_OFS_POLY: begin
        rd_mux[CRC_DATA_W-1:0] = poly;
      end
      CRC_OFS_IRQS: begin
        rd_mux[0] = irq_stat;
      end
      CRC_OFS_IRQM: begin
        rd_mux[0] = irq_mask;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data is registered during the wait state.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_o <= '0;
    end else if (rd_pend) begin
      hrdata_o <= rd_mux;
    end
  end

endmodule

// File: tb/crc_top_sva.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the shift FIFO block.
// ----------------------------------------
module crc_chk (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        sleep_i,
  input wire logic        idle_i,
  input wire logic        irq_o
);
  import crc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // A transfer is taken when the slave is ready and the master starts one.
  wire        take = hsel_i & hready_i & hreadyout_o & (htrans_i == CRC_HTRANS_NONSEQ);
  logic       ap_v, ap_w, rd_v, msk;  // Phase flags and the shadow mask.
  logic [7:0] ap_a, rd_a;             // Address of the phase in flight.
  logic [3:0] len;                    // Shadow of the length field.
  wire  [4:0] dep  = (len > CRC_LEN_BYTE_MAX) ? CRC_DEPTH_LONG : CRC_DEPTH_SHORT;
  wire        stat = rd_v && (rd_a == CRC_OFS_STAT);
  // Follows each transfer and mirrors the mask and length that software set.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ap_v <= 1'b0;
      ap_w <= 1'b0;
      rd_v <= 1'b0;
      msk  <= 1'b0;
      ap_a <= 8'h00;
      rd_a <= 8'h00;
      len  <= CRC_LEN_RST;
    end else begin
      ap_v <= take;
      ap_w <= hwrite_i;
      ap_a <= haddr_i[7:0];
      rd_v <= ap_v & ~ap_w;
      rd_a <= ap_a;
      if (ap_v && ap_w && (ap_a == CRC_OFS_IRQM)) begin
        msk <= hwdata_i[0];
      end
      if (ap_v && ap_w && (ap_a == CRC_OFS_CTRL)) begin
        len <= hwdata_i[11:8];
      end
    end
  end
  a_read_one_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  a_write_zero_wait: assert property (take && hwrite_i |=> hreadyout_o)
    else $error("write was stalled");
  a_rdata_holds: assert property (!$stable(hrdata_o) |-> rd_v)
    else $error("read data moved without a read");
  a_empty_flag: assert property (stat |-> hrdata_o[9] == (hrdata_o[4:0] == 5'h00))
    else $error("empty flag disagrees with count");
  a_full_flag: assert property (stat |-> hrdata_o[8] == (hrdata_o[4:0] == dep))
    else $error("full flag disagrees with count");
  a_count_bound: assert property (stat |-> hrdata_o[4:0] <= dep)
    else $error("count above depth");
  a_rem_width: assert property (rd_v && (rd_a == CRC_OFS_DATA) |->
    (hrdata_o >> (len + 5'h01)) == 32'h0) else $error("remainder too wide");
  a_irq_masked: assert property (irq_o |-> $past(msk))
    else $error("interrupt while masked");
  a_unmapped_zero: assert property (rd_v && (rd_a > CRC_OFS_IRQM) |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module tb_top;
  import crc_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------
  logic        clk = 1'b0, reset_n = 1'b0, hwrite = 1'b0, sleep = 1'b0, idle = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic        hready, hresp, irq;
  logic [15:0] e;
  int          failures = 0, n_tests = 0, n;
  logic [7:0]  ofs [7] = '{CRC_OFS_CTRL, CRC_OFS_STAT, CRC_OFS_POLY, CRC_OFS_RSLT,
                           CRC_OFS_IRQS, CRC_OFS_IRQM, 8'h1C};
  logic [31:0] rst [7] = '{32'h0F00, 32'h0200, 32'h1021, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [3:0]  c_len [3] = '{4'hF, 4'h7, 4'h5};
  logic [15:0] c_poly [3] = '{16'h1021, 16'h0007, 16'h0003};
  logic [15:0] c_w0 [3] = '{16'h1234, 16'h00A5, 16'h00FF};
  logic [15:0] c_w1 [3] = '{16'hABCD, 16'h013C, 16'h00C1};
  always #5 clk = ~clk;
  crc_top i_dut (.clk_i(clk), .reset_n_i(reset_n), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .sleep_i(sleep), .idle_i(idle), .irq_o(irq));
  // Waits for ready at a rising edge, within a bound.
  task automatic step(inout int k);
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
  endtask
  // One single-word transfer; read data lands in q.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    htrans <= CRC_HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h0, a};
    step(k);
    htrans <= 2'h0;
    hwdata <= d;
    step(k);
    q = hrdata;
    `CHK(hresp, 1'b0)
    if (k >= 50) begin
      failures++;
      print_verdict();
    end
  endtask
  // Counts cycles until the interrupt line is seen high.
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      failures++;
      print_verdict();
    end
  endtask
  // Reference remainder, one bit per step, top bit first.
  function automatic logic [15:0] crc(input logic [15:0] r, input logic [15:0] d,
                                      input int len, input logic [15:0] p);
    for (int i = len; i >= 0; i--) begin
      r = (r << 1) ^ ((d[i] ^ r[len]) ? p : 16'h0000);
    end
    return r & 16'((32'h1 << (len + 1)) - 1);
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 32'h0);
      `CHK(q, rst[i])
    end
    bus(1'b1, CRC_OFS_IRQM, 32'h1);
    // Fill to full at both depths, then one more write rolls over.
    for (int l = 0; l < 2; l++) begin
      bus(1'b1, CRC_OFS_CTRL, l ? 32'h0700 : 32'h0F00);
      for (int i = 1; i <= (l ? 16 : 8); i++) begin
        bus(1'b1, CRC_OFS_DATA, 32'h0000FF00 | i);
        @(posedge clk);
        bus(1'b0, CRC_OFS_STAT, 32'h0);
        `CHK(q, (i == (l ? 16 : 8) ? 32'h100 : 32'h0) | i)
      end
      bus(1'b1, CRC_OFS_DATA, 32'h0);
      @(posedge clk);
      bus(1'b0, CRC_OFS_STAT, 32'h0);
      `CHK(q, 32'h0200)
      bus(1'b0, CRC_OFS_IRQS, 32'h0);
      `CHK({q[0], irq}, 2'b00)
    end
    // Two words per length: idle without go, timing, result, interrupt.
    for (int c = 0; c < 3; c++) begin
      bus(1'b1, CRC_OFS_CTRL, {20'h0, c_len[c], 8'h00});
      bus(1'b1, CRC_OFS_POLY, {16'h0, c_poly[c]});
      bus(1'b1, CRC_OFS_RSLT, 32'h0);
      bus(1'b1, CRC_OFS_DATA, {16'h0, c_w0[c]});
      bus(1'b1, CRC_OFS_DATA, {16'h0, c_w1[c]});
      repeat (40) @(posedge clk);
      bus(1'b0, CRC_OFS_STAT, 32'h0);
      `CHK(q, 32'h0002)
      bus(1'b1, CRC_OFS_CTRL, {20'h0, c_len[c], 8'h01});
      wait_irq();
      `CHK(n >= 2 * (c_len[c] + 1) && n <= 2 * (c_len[c] + 1) + 4, 1'b1)
      bus(1'b0, CRC_OFS_STAT, 32'h0);
      `CHK(q, 32'h0200)
      e = crc(crc(16'h0, c_w0[c], c_len[c], c_poly[c]), c_w1[c], c_len[c], c_poly[c]);
      bus(1'b0, CRC_OFS_DATA, 32'h0);
      `CHK(q, {16'h0, e})
      bus(1'b1, CRC_OFS_IRQS, 32'h1);
      bus(1'b0, CRC_OFS_IRQS, 32'h0);
      `CHK({q[0], irq}, 2'b00)
    end
    // Sleep, idle with stop bit, idle without it; last pass masked.
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, CRC_OFS_IRQM, {31'h0, m != 2});
      sleep <= (m == 0);
      idle  <= (m != 0);
      bus(1'b1, CRC_OFS_CTRL, {20'h0, 4'h7, 6'h0, m == 1, 1'b1});
      bus(1'b1, CRC_OFS_DATA, 32'h5A);
      repeat (30) @(posedge clk);
      bus(1'b0, CRC_OFS_STAT, 32'h0);
      `CHK(q, m == 2 ? 32'h0200 : 32'h0001)
      sleep <= 1'b0;
      idle  <= 1'b0;
      repeat (30) @(posedge clk);
      bus(1'b0, CRC_OFS_IRQS, 32'h0);
      `CHK({q[0], irq}, {1'b1, m != 2})
      bus(1'b1, CRC_OFS_IRQS, 32'h1);
    end
    // A drain event left pending still reaches the pin while idle freezes the block.
    bus(1'b1, CRC_OFS_DATA, 32'h5A);
    repeat (20) @(posedge clk);
    idle <= 1'b1;
    bus(1'b1, CRC_OFS_CTRL, 32'h0703);
    bus(1'b1, CRC_OFS_IRQM, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    print_verdict();
  end
endmodule
bind crc_top crc_chk i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sleep_i(sleep_i), .idle_i(idle_i),
  .irq_o(irq_o));
